// ### verilog/sdram_cal_pkg.sv
// Constants shared by the memory-side model and the command issuer.
// Assumes both ends run on one clock; one beat of data per clock.
package sdram_cal_pkg;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int NUM_BANKS = 8;
  localparam int DQ_W = 16;
  localparam int TIMER_W = 8;
  localparam int BURST_W = 4;
  // Address bit positions
  localparam int CHOP_BIT = 12;
  localparam int AUTOCLOSE_BIT = 10;
  localparam int NIBBLE_BIT = 2;
  localparam int PAT_EN_BIT = 2;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'hAA; // beat index = bit number, starting at bit 0 or 4
  localparam logic [BURST_W-1:0] BEATS_EIGHT = 4'h8;
  localparam logic [BURST_W-1:0] BEATS_FOUR = 4'h4;
  localparam logic [2:0] NIBBLE_HIGH = 3'h4;
  // Clock counts at 4 ns per cycle
  localparam int CLK_PS = 4000;
  localparam int PRECHARGE_PERIOD_PS = 13750;
  localparam int MODE_SET_CMD_DELAY_PS = 16000;
  localparam int MODE_SET_UPDATE_DELAY_PS = 60000;
  localparam int PATTERN_READ_RECOVERY_PS = 4000;
  localparam logic [TIMER_W-1:0] PRECHARGE_CYC = TIMER_W'((PRECHARGE_PERIOD_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TIMER_W-1:0] MODE_SET_CYC =
    TIMER_W'((MODE_SET_CMD_DELAY_PS + MODE_SET_UPDATE_DELAY_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TIMER_W-1:0] RECOVERY_CYC = TIMER_W'((PATTERN_READ_RECOVERY_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TIMER_W-1:0] COLUMN_CMD_SPACING = 8'h04;
  localparam logic [TIMER_W-1:0] ADDITIVE_LATENCY = 8'h00;
  localparam logic [TIMER_W-1:0] CAS_LATENCY = 8'h06;
  localparam logic [TIMER_W-1:0] READ_LATENCY = TIMER_W'(ADDITIVE_LATENCY + CAS_LATENCY);
  // Pending countdown: two register stages follow it before the first beat
  localparam logic [TIMER_W-1:0] READ_PIPE_CYC = TIMER_W'(ADDITIVE_LATENCY + CAS_LATENCY - 2);
  // Bus command codes
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVATE, CMD_PRECHARGE, CMD_PRECHARGE_ALL,
    CMD_READ, CMD_WRITE, CMD_MODE_SET
  } mem_cmd_t;
  // Avalon register map of the command issuer
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hC;
endpackage : sdram_cal_pkg

// ### verilog/sdram_link_if.sv
// Command and data link between the command issuer and the memory model.
// Assumes one shared clock; issuer drives commands, memory drives data.
`timescale 1ns/100ps
`default_nettype none
interface sdram_link_if;
  import sdram_cal_pkg::*;
  mem_cmd_t cmd;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0] addr;
  logic [DQ_W-1:0] dq;
  logic dq_valid;
  modport memory (input cmd, bank, addr, output dq, dq_valid);
  modport issuer (output cmd, bank, addr, input dq, dq_valid);
endinterface : sdram_link_if
`default_nettype wire

// ### verilog/sdram_pattern_mem.sv
// Memory-side model: bank state, calibration pattern readout, bursts.
// Assumes the issuer keeps the command spacing and mode-set waits.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sdram_pattern_mem
  import sdram_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  sdram_link_if.memory link,
  // Status
  output logic pattern_mode,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic [NUM_BANKS-1:0] bank_ready,
  output logic [ROW_W-1:0] open_row [NUM_BANKS],
  output logic illegal_cmd
);
  logic [1:0] loc_reg;
  logic [TIMER_W-1:0] lat_reg [NUM_BANKS];
  logic [TIMER_W-1:0] pipe_cnt_reg;
  logic [BURST_W-1:0] beats_reg;
  logic [2:0] beat_idx_reg;
  logic pend_reg;
  logic pend_pattern_reg;
  logic [BURST_W-1:0] pend_beats_reg;
  logic [2:0] pend_start_reg;
  logic [ROW_W-1:0] pend_col_reg;
  logic [ROW_W-1:0] burst_col_reg;
  logic burst_pattern_reg;
  logic is_read;

  assign is_read = (link.cmd == CMD_READ);

  // Mode set: enable bit and location
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pattern_mode <= 1'b0;
      loc_reg <= 2'h0;
    end else if (link.cmd == CMD_MODE_SET) begin
      pattern_mode <= link.addr[PAT_EN_BIT];
      loc_reg <= link.addr[1:0];
    end
  end

  // Per-bank open flags, rows and precharge timers
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (link.bank == BANK_W'(b));
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          bank_open[b] <= 1'b0;
          open_row[b] <= '0;
          lat_reg[b] <= '0;
        end else begin
          if (link.cmd == CMD_ACTIVATE && hit) begin
            bank_open[b] <= 1'b1;
            open_row[b] <= link.addr;
          end else if ((link.cmd == CMD_PRECHARGE && hit) || link.cmd == CMD_PRECHARGE_ALL) begin
            bank_open[b] <= 1'b0;
            lat_reg[b] <= PRECHARGE_CYC;
          end else if (lat_reg[b] != '0) begin
            lat_reg[b] <= lat_reg[b] - 1'b1;
          end
        end
      end
      assign bank_ready[b] = !bank_open[b] && (lat_reg[b] == '0);
    end
  endgenerate

  // Flags commands not allowed while pattern mode is on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      illegal_cmd <= 1'b0;
    end else begin
      illegal_cmd <= pattern_mode && (link.cmd != CMD_NOP) && !is_read
                     && (link.cmd != CMD_MODE_SET);
    end
  end

  // Read accepted: wait read latency, then burst
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      pend_pattern_reg <= 1'b0;
      pend_beats_reg <= '0;
      pend_start_reg <= '0;
      pend_col_reg <= '0;
      pipe_cnt_reg <= '0;
    end else if (is_read) begin
      pend_reg <= 1'b1;
      pend_pattern_reg <= pattern_mode;
      pend_beats_reg <= link.addr[CHOP_BIT] ? BEATS_EIGHT : BEATS_FOUR;
      pend_start_reg <= link.addr[NIBBLE_BIT] ? NIBBLE_HIGH : 3'h0;
      pend_col_reg <= link.addr;
      pipe_cnt_reg <= READ_PIPE_CYC;
    end else if (pend_reg) begin
      if (pipe_cnt_reg == '0) begin
        pend_reg <= 1'b0;
      end else begin
        pipe_cnt_reg <= pipe_cnt_reg - 1'b1;
      end
    end
  end

  // Burst sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      beats_reg <= '0;
      beat_idx_reg <= '0;
      burst_pattern_reg <= 1'b0;
      burst_col_reg <= '0;
    end else if (pend_reg && pipe_cnt_reg == '0) begin
      beats_reg <= pend_beats_reg;
      beat_idx_reg <= pend_start_reg;
      burst_pattern_reg <= pend_pattern_reg;
      burst_col_reg <= pend_col_reg;
    end else if (beats_reg != '0) begin
      beats_reg <= beats_reg - 1'b1;
      beat_idx_reg <= beat_idx_reg + 1'b1;
    end
  end

  // Data out: pattern bit copied to all lanes, array returns column
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.dq <= '0;
      link.dq_valid <= 1'b0;
    end else begin
      link.dq_valid <= (beats_reg != '0);
      if (beats_reg == '0) begin
        link.dq <= '0;
      end else if (burst_pattern_reg) begin
        // Reserved locations read as zero
        link.dq <= (loc_reg == LOC_PATTERN && CAL_PATTERN[beat_idx_reg]) ? '1 : '0;
      end else begin
        link.dq <= DQ_W'({burst_col_reg[ROW_W-1:3], beat_idx_reg});
      end
    end
  end
endmodule : sdram_pattern_mem
`default_nettype wire

// ### verilog/sdram_cal_issuer.sv
// Command issuer: Avalon-MM slave taking orders, drives link with waits.
// Assumes the memory model follows the issued command stream.
`timescale 1ns/100ps
`default_nettype none
module sdram_cal_issuer
  import sdram_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link
  sdram_link_if.issuer link
);
  typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} state_t;
  state_t state_reg;
  logic [2:0] op_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [ROW_W-1:0] addr_reg;
  logic [TIMER_W-1:0] wait_reg;
  logic [TIMER_W-1:0] wait_next;
  logic pat_on_reg;
  logic [DQ_W-1:0] data_reg;
  logic refused_reg;
  logic cmd_ok;

  // Write to command register refused in pattern mode unless read/mode set
  assign cmd_ok = !(pat_on_reg && (mem_cmd_t'(avs_writedata[2:0]) != CMD_READ)
                    && (mem_cmd_t'(avs_writedata[2:0]) != CMD_MODE_SET));
  assign avs_waitrequest = (avs_write && avs_address == REG_CMD && state_reg != ST_IDLE);

  // Spacing after each command
  always_comb begin
    wait_next = '0;
    case (mem_cmd_t'(op_reg))
      CMD_PRECHARGE, CMD_PRECHARGE_ALL: wait_next = PRECHARGE_CYC;
      CMD_MODE_SET: wait_next = MODE_SET_CYC;
      CMD_READ: begin
        if (addr_reg[CHOP_BIT]) begin
          wait_next = BEATS_EIGHT / 2 + RECOVERY_CYC;
        end else begin
          wait_next = COLUMN_CMD_SPACING;
        end
      end
      default: wait_next = '0;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_reg <= '0;
      bank_reg <= '0;
      addr_reg <= '0;
      wait_reg <= '0;
      pat_on_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (avs_write && avs_address == REG_ADDR) begin
            bank_reg <= avs_writedata[ROW_W+BANK_W-1:ROW_W];
            addr_reg <= avs_writedata[ROW_W-1:0];
          end else if (avs_write && avs_address == REG_CMD) begin
            refused_reg <= !cmd_ok;
            if (cmd_ok) begin
              op_reg <= avs_writedata[2:0];
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          if (mem_cmd_t'(op_reg) == CMD_MODE_SET) begin
            pat_on_reg <= addr_reg[PAT_EN_BIT];
          end
          wait_reg <= wait_next;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (wait_reg <= 8'h01) begin
            state_reg <= ST_IDLE;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Drive link for one cycle in ST_ISSUE
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.cmd <= CMD_NOP;
      link.bank <= '0;
      link.addr <= '0;
    end else begin
      link.cmd <= (state_reg == ST_IDLE && avs_write && avs_address == REG_CMD && cmd_ok)
                  ? mem_cmd_t'(avs_writedata[2:0]) : CMD_NOP;
      link.bank <= bank_reg;
      link.addr <= addr_reg;
    end
  end

  // Capture last returned beat
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= '0;
    end else if (link.dq_valid) begin
      data_reg <= link.dq;
    end
  end

  // Read mux
  always_comb begin
    case (avs_address)
      REG_ADDR: avs_readdata = {15'h0000, bank_reg, addr_reg};
      REG_STATUS: avs_readdata = {29'h00000000, refused_reg, pat_on_reg, state_reg != ST_IDLE};
      REG_DATA: avs_readdata = {16'h0000, data_reg};
      default: avs_readdata = 32'h00000000;
    endcase
  end
endmodule : sdram_cal_issuer
`default_nettype wire

// ### tb/sdram_link_checker.sv
// Link checker: timing and data of commands and read bursts.
// Assumes one clock; inputs are the link signals of the interface.
`timescale 1ns/100ps
`default_nettype none
module sdram_link_checker
  import sdram_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire mem_cmd_t cmd,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ROW_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq,
  input wire logic dq_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic pat_on_reg;
  logic rd;
  assign rd = (cmd == CMD_READ);
  // Pattern mode as last set on the link, location 00 only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pat_on_reg <= 1'b0;
    else if (cmd == CMD_MODE_SET) pat_on_reg <= addr[PAT_EN_BIT] && (addr[1:0] == LOC_PATTERN);
  end
  // Two beats of the alternating pattern
  sequence alt_pair;
    dq == 16'h0000 ##1 dq == 16'hFFFF;
  endsequence
  property array_beat;
    logic [ROW_W-1:0] a;
    (rd && !pat_on_reg && !addr[CHOP_BIT], a = addr) |-> ##7 dq == {2'h0, a[13:3], 3'h0};
  endproperty
  eight_len_a: assert property (rd && addr[CHOP_BIT] |-> ##7 dq_valid [*8])
    else $error("eight-beat burst length or latency wrong");
  chop_len_a: assert property (rd && !addr[CHOP_BIT] |-> ##7 dq_valid [*4] ##1 (!dq_valid || $past(rd, 7)))
    else $error("chopped burst length wrong");
  pat_eight_a: assert property (pat_on_reg && rd && addr[CHOP_BIT] |-> ##7 alt_pair ##1 alt_pair ##1 alt_pair ##1 alt_pair)
    else $error("eight-beat pattern wrong");
  pat_chop_a: assert property (pat_on_reg && rd && !addr[CHOP_BIT] |-> ##7 alt_pair ##1 alt_pair)
    else $error("chopped pattern wrong");
  array_data_a: assert property (array_beat)
    else $error("array read data wrong");
  pat_cmds_a: assert property (pat_on_reg |-> cmd inside {CMD_NOP, CMD_READ, CMD_MODE_SET})
    else $error("command not allowed in pattern mode");
  chop_space_a: assert property (rd && !addr[CHOP_BIT] |=> !(cmd inside {CMD_READ, CMD_WRITE}) [*3])
    else $error("column commands too close");
  mode_wait_a: assert property (cmd == CMD_MODE_SET |=> (cmd == CMD_NOP) [*8])
    else $error("command too soon after mode set");
  pre_wait_a: assert property (cmd == CMD_PRECHARGE_ALL |=> (cmd == CMD_NOP) [*3])
    else $error("command too soon after precharge all");
endmodule : sdram_link_checker
`default_nettype wire

// ### tb/tb_sdram_calib_pattern_and_bank_cmds.sv
// Testbench: issuer and memory joined by the link, driven over Avalon.
// Assumes a 250 MHz clock and the register map of the package.
`timescale 1ns/100ps
`default_nettype none
module tb_sdram_calib_pattern_and_bank_cmds;
  import sdram_cal_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pattern_mode;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] bank_ready;
  logic [ROW_W-1:0] open_row [NUM_BANKS];
  logic illegal_cmd;
  logic [15:0] beats [$];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Clock
  always #2 clk = ~clk;
  sdram_link_if sdram_link_if_inst ();
  sdram_cal_issuer sdram_cal_issuer_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(sdram_link_if_inst));
  sdram_pattern_mem sdram_pattern_mem_inst (.clk(clk), .resetn(resetn), .link(sdram_link_if_inst),
    .pattern_mode(pattern_mode), .bank_open(bank_open), .bank_ready(bank_ready),
    .open_row(open_row), .illegal_cmd(illegal_cmd));
  sdram_link_checker sdram_link_checker_inst (.clk(clk), .resetn(resetn), .cmd(sdram_link_if_inst.cmd),
    .bank(sdram_link_if_inst.bank), .addr(sdram_link_if_inst.addr), .dq(sdram_link_if_inst.dq),
    .dq_valid(sdram_link_if_inst.dq_valid));
  // Beat capture and hang guard
  always @(posedge clk) begin
    if (sdram_link_if_inst.dq_valid === 1'b1) beats.push_back(sdram_link_if_inst.dq);
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // Avalon access held until waitrequest is seen low at an edge
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
    end while (w !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  task cmd(input mem_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    logic [31:0] q;
    int i;
    av(1'b1, REG_ADDR, {15'h0, b, a}, q);
    av(1'b1, REG_CMD, {29'h0, c}, q);
    for (i = 0; i < 100; i++) begin
      av(1'b0, REG_STATUS, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
  endtask : cmd
  // Read and judge the burst: m 0 array, 1 pattern, 2 zeros
  task rd(input logic [13:0] a, input int n, input int m);
    logic [15:0] e;
    int k;
    beats.delete();
    cmd(CMD_READ, 3'h5, a);
    repeat (16) @(posedge clk);
    chk(32'(beats.size()), 32'(n), "beat count");
    for (k = 0; k < n; k++) begin
      e = (m == 1) ? {16{CAL_PATTERN[k + (a[2] ? 4 : 0)]}} : (m == 0) ? {2'h0, a[13:3], 3'(k)} : 16'h0;
      chk(beats[k], e, "beat data");
    end
  endtask : rd
  task t_banks();
    cmd(CMD_ACTIVATE, 3'h3, 14'h1234);
    cmd(CMD_ACTIVATE, 3'h7, 14'h0ABC);
    chk(bank_open, 8'h88, "banks open");
    chk(open_row[3], 14'h1234, "row of bank 3");
    chk(open_row[7], 14'h0ABC, "row of bank 7");
    cmd(CMD_PRECHARGE, 3'h3, 14'h0);
    chk(bank_open, 8'h80, "one bank closed");
    cmd(CMD_PRECHARGE, 3'h3, 14'h0);
    chk(illegal_cmd, 1'b0, "repeat precharge");
    cmd(CMD_PRECHARGE_ALL, 3'h0, 14'h0);
    chk(bank_open, 8'h00, "all closed");
    chk(bank_ready, 8'hFF, "all idle");
    $display("test banks done");
  endtask : t_banks
  task t_pattern();
    logic [31:0] q;
    cmd(CMD_MODE_SET, 3'h0, 14'h0004);
    chk(pattern_mode, 1'b1, "pattern mode on");
    rd(14'h1000, 8, 1);
    rd(14'h1000, 8, 1);
    rd(14'h0000, 4, 1);
    rd(14'h0004, 4, 1);
    cmd(CMD_WRITE, 3'h0, 14'h0);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q[2:1], 2'h3, "write refused");
    cmd(CMD_MODE_SET, 3'h0, 14'h0005);
    rd(14'h1000, 8, 2);
    cmd(CMD_MODE_SET, 3'h0, 14'h0000);
    chk(pattern_mode, 1'b0, "pattern mode off");
    $display("test pattern done");
  endtask : t_pattern
  task t_array();
    cmd(CMD_ACTIVATE, 3'h5, 14'h0040);
    rd(14'h0028, 4, 0);
    cmd(CMD_PRECHARGE_ALL, 3'h0, 14'h0);
    chk(bank_open, 8'h00, "closed after use");
    $display("test array done");
  endtask : t_array
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_banks();
    t_pattern();
    t_array();
    report_and_stop();
  end
endmodule : tb_sdram_calib_pattern_and_bank_cmds
`default_nettype wire
